//--- hdl/ciu_pkg.sv
// Package: constants, register map and request carrier of the central interrupt unit
package ciu_pkg;

    // Channel count and index width
    localparam int CIU_CHANNELS = 32;
    localparam int CIU_IDX_W = 5;

    // Register bus widths
    localparam int CIU_ADDR_W = 8;
    localparam int CIU_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CIU_OFS_PENDING = 8'h00;    // Pending, write one to clear
    localparam logic [7:0] CIU_OFS_ENABLE = 8'h04;     // Per channel enable mask
    localparam logic [7:0] CIU_OFS_FAST_SEL = 8'h08;   // One routes channel to fast output
    localparam logic [7:0] CIU_OFS_FAST_IDX = 8'h0C;   // Fast vector index, read only
    localparam logic [7:0] CIU_OFS_NORM_IDX = 8'h10;   // Normal vector index, read only
    localparam logic [7:0] CIU_OFS_SW_REQ = 8'h14;     // Software request control
    localparam logic [7:0] CIU_OFS_EVT_STATUS = 8'h18; // Sticky events, cleared by read
    localparam logic [7:0] CIU_OFS_EVT_MASK = 8'h1C;   // Event interrupt mask

    // Field positions
    localparam int CIU_IDX_VALID_BIT = 8;   // Index register: a channel is pending
    localparam int CIU_SW_REQ_BIT = 0;      // Software request control bit
    localparam int CIU_EVT_OVERRUN_BIT = 0; // Request edge on an already pending channel
    localparam int CIU_EVT_CAPTURE_BIT = 1; // Any request captured
    localparam int CIU_EVT_W = 2;
    localparam int CIU_SW_CHANNEL = 31;     // Channel raised by software control

    // Values after reset
    localparam logic [31:0] CIU_RST_PENDING = 32'h00000000;
    localparam logic [31:0] CIU_RST_ENABLE = 32'h00000000;
    localparam logic [31:0] CIU_RST_FAST_SEL = 32'h00000000;
    localparam logic [1:0] CIU_RST_EVT = 2'h0;
    localparam logic [31:0] CIU_RST_RDATA = 32'h00000000;

    // Request sources, channel 31 at the top down to channel 0
    typedef struct packed {
        logic software_system_request;        // 31, highest
        logic fault_pin_request;              // 30
        logic pwm_module_zero_request;        // 29
        logic pwm_module_one_request;         // 28
        logic pwm_module_two_request;         // 27
        logic pwm_module_three_request;       // 26
        logic fault_mux_request;              // 25
        logic conversion_done_request;        // 24
        logic power_current_mode_request;     // 23
        logic wide_timer_compare_zero_request; // 22
        logic wide_timer_capture_zero_request; // 21
        logic wide_timer_compare_one_request; // 20
        logic dead_time_fault_request;        // 19
        logic wide_timer_overflow_request;    // 18
        logic timer_pwm_zero_request;         // 17
        logic timer_pwm_one_request;          // 16
        logic timer_pwm_two_request;          // 15
        logic timer_pwm_three_request;        // 14
        logic front_end_two_request;          // 13
        logic front_end_one_request;          // 12
        logic front_end_zero_request;         // 11
        logic digital_comparator_request;     // 10
        logic pmbus_request;                  // 9
        logic serial1_transmit_request;       // 8
        logic serial1_receive_request;        // 7
        logic serial0_transmit_request;       // 6
        logic serial0_receive_request;        // 5
        logic serial_error_request;           // 4
        logic watchdog_half_request;          // 3
        logic watchdog_expiry_request;        // 2
        logic external_pin_request;           // 1
        logic brownout_request;               // 0, lowest
    } ciu_sources_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ciu_bus_req_t;

endpackage : ciu_pkg

//--- hdl/ciu_prio_enc.sv
// Fixed precedence encoder: highest set bit wins
`timescale 1ns/1ps
module ciu_prio_enc #(
    parameter int N = 32,
    parameter int W = 5
) (
    input wire logic [N-1:0] vec_i,
    output logic [W-1:0] idx_o,
    output logic any_o
);

    // Ascending scan, so a higher channel overrides every lower one
    always_comb begin
        idx_o = '0;
        any_o = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (vec_i[i]) begin
                idx_o = W'(i);
                any_o = 1'b1;
            end
        end
    end

endmodule : ciu_prio_enc

//--- hdl/ciu_top.sv
// Central interrupt unit: capture, mask, routing, precedence and vector index
//
// Contract
// - Thirty-two request inputs, one fixed source each
// - Drive fast and normal outputs; both may stand, the core takes fast first
// - Per level, index of highest pending channel readable
// - Higher channel number always wins within a level; zero lowest
// - Disabled channel asserts neither level, never wins index
// - Captured request pending until firmware clears it
// - Channels 0-3: brownout, pin, watchdog, watchdog half
// - Channel 4: combined serial port error request
// - Channels 5-8: serial receive/transmit, ports zero, one
// - Channel 9 PMBus, channel 10 digital comparator
// - Channels 11-13: front ends zero to two
// - Channels 14-17: timers three down to zero
// - Channels 18-20: overflow, dead-time fault, compare one
// - Channels 21-25: capture, compare, mode, conversion, fault
// - 26-29 modulators three-zero; 30 fault pin; 31 software
`timescale 1ns/1ps
module ciu_top (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input ciu_pkg::ciu_sources_t SOURCES_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    output logic FAST_IRQ_OUTPUT_O,
    output logic NORMAL_IRQ_O,
    output logic EVT_IRQ_O
);

    // Flat request vector, bit n is channel n
    logic [31:0] req_vec;
    // Previous request levels for edge capture
    logic [31:0] req_prev_r;
    logic [31:0] req_prev_nxt;
    // Rising edges this cycle
    logic [31:0] edge_set;
    // Write-one-to-clear mask this cycle
    logic [31:0] clr_mask;
    // Pending, enable and routing state
    logic [31:0] pending_r;
    logic [31:0] pending_nxt;
    logic [31:0] enable_r;
    logic [31:0] enable_nxt;
    logic [31:0] fast_sel_r;
    logic [31:0] fast_sel_nxt;
    logic sw_req_r;
    logic sw_req_nxt;
    // Event status and mask
    logic [1:0] evt_status_r;
    logic [1:0] evt_status_nxt;
    logic [1:0] evt_mask_r;
    logic [1:0] evt_mask_nxt;
    logic [1:0] evt_set;
    // Per level candidate vectors
    logic [31:0] fast_vec;
    logic [31:0] norm_vec;
    // Encoder results
    logic [4:0] fast_idx;
    logic fast_any;
    logic [4:0] norm_idx;
    logic norm_any;
    // Registered index and outputs
    logic [4:0] fast_idx_r;
    logic [4:0] fast_idx_nxt;
    logic fast_valid_r;
    logic fast_valid_nxt;
    logic [4:0] norm_idx_r;
    logic [4:0] norm_idx_nxt;
    logic norm_valid_r;
    logic norm_valid_nxt;
    logic fast_irq_r;
    logic fast_irq_nxt;
    logic norm_irq_r;
    logic norm_irq_nxt;
    logic evt_irq_r;
    logic evt_irq_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    // Decoded strobes
    logic rd_evt;

    // Source map, the struct already places each source on its channel
    always_comb begin
        req_vec = SOURCES_I;
        // Software control shares the top channel with the core source
        req_vec[ciu_pkg::CIU_SW_CHANNEL] = SOURCES_I.software_system_request | sw_req_r;
    end

    // Capture and clear; a set in the clearing cycle wins
    always_comb begin
        req_prev_nxt = req_vec;
        edge_set = req_vec & ~req_prev_r;
        clr_mask = '0;
        if (WR_I && ADDR_I == ciu_pkg::CIU_OFS_PENDING) begin
            clr_mask = WDATA_I;
        end
        pending_nxt = (pending_r & ~clr_mask) | edge_set;
    end

    // Capture registers
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            req_prev_r <= ciu_pkg::CIU_RST_PENDING;
            pending_r <= ciu_pkg::CIU_RST_PENDING;
        end else begin
            req_prev_r <= req_prev_nxt;
            pending_r <= pending_nxt;
        end
    end

    // Software writable control
    always_comb begin
        enable_nxt = enable_r;
        fast_sel_nxt = fast_sel_r;
        sw_req_nxt = sw_req_r;
        evt_mask_nxt = evt_mask_r;
        if (WR_I) begin
            unique case (ADDR_I)
                ciu_pkg::CIU_OFS_ENABLE: begin
                    enable_nxt = WDATA_I;
                end
                ciu_pkg::CIU_OFS_FAST_SEL: begin
                    fast_sel_nxt = WDATA_I;
                end
                ciu_pkg::CIU_OFS_SW_REQ: begin
                    sw_req_nxt = WDATA_I[ciu_pkg::CIU_SW_REQ_BIT];
                end
                ciu_pkg::CIU_OFS_EVT_MASK: begin
                    evt_mask_nxt = WDATA_I[1:0];
                end
                default: begin
                    // Other offsets hold no writable control
                end
            endcase
        end
    end

    // Control registers
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            enable_r <= ciu_pkg::CIU_RST_ENABLE;
            fast_sel_r <= ciu_pkg::CIU_RST_FAST_SEL;
            sw_req_r <= 1'b0;
            evt_mask_r <= ciu_pkg::CIU_RST_EVT;
        end else begin
            enable_r <= enable_nxt;
            fast_sel_r <= fast_sel_nxt;
            sw_req_r <= sw_req_nxt;
            evt_mask_r <= evt_mask_nxt;
        end
    end

    // Masking and routing ahead of the encoders
    always_comb begin
        fast_vec = pending_r & enable_r & fast_sel_r;
        norm_vec = pending_r & enable_r & ~fast_sel_r;
    end

    // One encoder per level
    ciu_prio_enc #(
        .N(ciu_pkg::CIU_CHANNELS),
        .W(ciu_pkg::CIU_IDX_W)
    ) u_fast_enc (
        .vec_i(fast_vec),
        .idx_o(fast_idx),
        .any_o(fast_any)
    );

    ciu_prio_enc #(
        .N(ciu_pkg::CIU_CHANNELS),
        .W(ciu_pkg::CIU_IDX_W)
    ) u_norm_enc (
        .vec_i(norm_vec),
        .idx_o(norm_idx),
        .any_o(norm_any)
    );

    // Sticky events; a new event in the reading cycle survives the clear
    always_comb begin
        rd_evt = RD_I && (ADDR_I == ciu_pkg::CIU_OFS_EVT_STATUS);
        evt_set = '0;
        evt_set[ciu_pkg::CIU_EVT_OVERRUN_BIT] = |(edge_set & pending_r & ~clr_mask);
        evt_set[ciu_pkg::CIU_EVT_CAPTURE_BIT] = |edge_set;
        evt_status_nxt = (rd_evt ? ciu_pkg::CIU_RST_EVT : evt_status_r) | evt_set;
    end

    // Vector index and output next values
    always_comb begin
        fast_idx_nxt = fast_idx;
        fast_valid_nxt = fast_any;
        norm_idx_nxt = norm_idx;
        norm_valid_nxt = norm_any;
        // Both levels may stand; the core itself takes fast first
        fast_irq_nxt = fast_any;
        norm_irq_nxt = norm_any;
        evt_irq_nxt = |(evt_status_r & evt_mask_r);
    end

    // Index, status and output registers
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fast_idx_r <= '0;
            fast_valid_r <= 1'b0;
            norm_idx_r <= '0;
            norm_valid_r <= 1'b0;
            fast_irq_r <= 1'b0;
            norm_irq_r <= 1'b0;
            evt_irq_r <= 1'b0;
            evt_status_r <= ciu_pkg::CIU_RST_EVT;
        end else begin
            fast_idx_r <= fast_idx_nxt;
            fast_valid_r <= fast_valid_nxt;
            norm_idx_r <= norm_idx_nxt;
            norm_valid_r <= norm_valid_nxt;
            fast_irq_r <= fast_irq_nxt;
            norm_irq_r <= norm_irq_nxt;
            evt_irq_r <= evt_irq_nxt;
            evt_status_r <= evt_status_nxt;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = '0;
        if (RD_I) begin
            unique case (ADDR_I)
                ciu_pkg::CIU_OFS_PENDING: rdata_nxt = pending_r;
                ciu_pkg::CIU_OFS_ENABLE: rdata_nxt = enable_r;
                ciu_pkg::CIU_OFS_FAST_SEL: rdata_nxt = fast_sel_r;
                ciu_pkg::CIU_OFS_FAST_IDX: begin
                    rdata_nxt[4:0] = fast_idx_r;
                    rdata_nxt[ciu_pkg::CIU_IDX_VALID_BIT] = fast_valid_r;
                end
                ciu_pkg::CIU_OFS_NORM_IDX: begin
                    rdata_nxt[4:0] = norm_idx_r;
                    rdata_nxt[ciu_pkg::CIU_IDX_VALID_BIT] = norm_valid_r;
                end
                ciu_pkg::CIU_OFS_SW_REQ: rdata_nxt[ciu_pkg::CIU_SW_REQ_BIT] = sw_req_r;
                ciu_pkg::CIU_OFS_EVT_STATUS: rdata_nxt[1:0] = evt_status_r;
                ciu_pkg::CIU_OFS_EVT_MASK: rdata_nxt[1:0] = evt_mask_r;
                default: rdata_nxt = '0;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata_r <= ciu_pkg::CIU_RST_RDATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flops
    assign RDATA_O = rdata_r;
    assign FAST_IRQ_OUTPUT_O = fast_irq_r;
    assign NORMAL_IRQ_O = norm_irq_r;
    assign EVT_IRQ_O = evt_irq_r;

    // Checks, all in the single clock domain
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!NRST_I);

    AST_CAPTURE: assert property (
        (|edge_set) |=> ((pending_r & $past(edge_set)) == $past(edge_set)))
        else $error("Request edge not captured as pending");

    AST_HOLD: assert property (
        1'b1 |=> ((($past(pending_r) & ~pending_r) & ~$past(clr_mask)) == 32'h00000000))
        else $error("Pending bit dropped without a clear");

    AST_MASK_FAST: assert property (
        FAST_IRQ_OUTPUT_O |-> $past(|(pending_r & enable_r & fast_sel_r)))
        else $error("Fast output without an enabled routed pending channel");

    // The output register follows the routed vector one edge later, so a clear
    // or mask write in the same cycle cannot hide a missing rise
    AST_NORMAL_LEVEL: assert property (
        (|(pending_r & enable_r & ~fast_sel_r)) |=> NORMAL_IRQ_O)
        else $error("Normal output missing for enabled pending channel");

    AST_PRIO_FAST: assert property (
        fast_valid_r |-> (($past(fast_vec) >> fast_idx_r) == 32'h00000001))
        else $error("Fast index is not the highest pending channel");

    // Index is taken as it stands now, routing and mask as they stood one edge back
    AST_ROUTE_NORMAL: assert property (
        norm_valid_r |->
            (((($past(fast_sel_r) | ~$past(enable_r)) >> norm_idx_r) & 32'h00000001)
                == 32'h00000000))
        else $error("Normal index names a fast or disabled channel");

    AST_SW_RAISE: assert property (
        $rose(sw_req_r) |-> ##1 pending_r[31])
        else $error("Software control did not raise top channel");

    AST_EVT_READ: assert property (
        rd_evt |=> (evt_status_r == $past(evt_set)))
        else $error("Event status not cleared by read");

endmodule : ciu_top

//--- tb/ciu_core_model.sv
// Processor side model: takes the fast level before the normal level
`timescale 1ns/1ps
module ciu_core_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fast_i,
    input wire logic norm_i,
    output logic [1:0] taken_o
);
    // Level taken this cycle: 2'h2 fast, 2'h1 normal, 2'h0 idle
    logic [1:0] taken_nxt;

    // Fast request shadows a normal one, as in the real core
    always_comb begin
        taken_nxt = fast_i ? 2'h2 : (norm_i ? 2'h1 : 2'h0);
    end

    // Register the level taken
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            taken_o <= 2'h0;
        end else begin
            taken_o <= taken_nxt;
        end
    end
endmodule : ciu_core_model

//--- tb/tb_central_interrupt_module.sv
// Self-checking bench of the central interrupt unit
`timescale 1ns/1ps
module tb_central_interrupt_module;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    ciu_pkg::ciu_sources_t src = '0; // Request lines, bit n is channel n
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic fast_irq;
    logic norm_irq;
    logic evt_irq;
    logic [1:0] taken; // Level the core model accepted
    logic [31:0] d; // Last read word
    ciu_pkg::ciu_sources_t s; // Scratch source pattern
    int n_fail = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    ciu_top uut (
        .CLOCK_I(clk),
        .NRST_I(nrst),
        .SOURCES_I(src),
        .ADDR_I(addr),
        .WDATA_I(wdata),
        .WR_I(wr),
        .RD_I(rd),
        .RDATA_O(rdata),
        .FAST_IRQ_OUTPUT_O(fast_irq),
        .NORMAL_IRQ_O(norm_irq),
        .EVT_IRQ_O(evt_irq)
    );

    ciu_core_model core (
        .clk_i(clk),
        .nrst_i(nrst),
        .fast_i(fast_irq),
        .norm_i(norm_irq),
        .taken_o(taken)
    );

    // Verdict and end of run
    task automatic finish_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Wait cycles, then step off the edge so outputs have settled
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // One cycle write
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr

    // One cycle read, data taken in the following cycle only
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : bus_rd

    // Read and compare a register
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus_rd(a, d);
        chk(d, exp);
    endtask : rd_chk

    // Drive the request lines
    task automatic drive(input logic [31:0] v);
        @(posedge clk);
        src <= v;
    endtask : drive

    // Drop lines before clearing, else a held line would give no new edge on the next drive
    task automatic quiet;
        drive(32'h00000000);
        wait_clk(2);
        bus_wr(ciu_pkg::CIU_OFS_PENDING, 32'hFFFFFFFF);
        wait_clk(3);
    endtask : quiet

    // Reset values, read-only and unmapped places
    task automatic t_reset;
        chk({fast_irq, norm_irq, evt_irq}, 3'h0);
        rd_chk(ciu_pkg::CIU_OFS_ENABLE, ciu_pkg::CIU_RST_ENABLE);
        rd_chk(ciu_pkg::CIU_OFS_FAST_SEL, ciu_pkg::CIU_RST_FAST_SEL);
        rd_chk(ciu_pkg::CIU_OFS_PENDING, ciu_pkg::CIU_RST_PENDING);
        rd_chk(ciu_pkg::CIU_OFS_SW_REQ, 32'h00000000);
        rd_chk(ciu_pkg::CIU_OFS_EVT_MASK, 32'h00000000);
        bus_wr(8'h20, 32'hFFFFFFFF);
        bus_wr(ciu_pkg::CIU_OFS_NORM_IDX, 32'hFFFFFFFF);
        rd_chk(8'h20, 32'h00000000);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000000);
    endtask : t_reset

    // Capture, hold after the line drops, clear by firmware
    task automatic t_walk;
        bus_wr(ciu_pkg::CIU_OFS_ENABLE, 32'hFFFFFFFF);
        drive(32'h00000020);
        wait_clk(5);
        chk({fast_irq, norm_irq, taken}, 4'h5);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000105);
        wait_clk(1);
        chk(rdata, 32'h00000000);
        drive(32'h00000000);
        wait_clk(3);
        rd_chk(ciu_pkg::CIU_OFS_PENDING, 32'h00000020);
        chk(norm_irq, 1'b1);
        bus_wr(ciu_pkg::CIU_OFS_PENDING, 32'h00000020);
        wait_clk(3);
        chk(norm_irq, 1'b0);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000000);
    endtask : t_walk

    // Channels 0..n pending: highest number must win
    task automatic t_prec;
        for (int n = 0; n < 32; n++) begin
            quiet();
            drive(32'hFFFFFFFF >> (31 - n));
            wait_clk(4);
            rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000100 | n);
        end
    endtask : t_prec

    // Single named source must land on its channel
    task automatic one_ch(input ciu_pkg::ciu_sources_t v, input int n);
        quiet();
        drive(v);
        wait_clk(4);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000100 | n);
    endtask : one_ch

    // Source map spot checks
    task automatic t_map;
        s = '0;
        s.watchdog_half_request = 1'b1;
        one_ch(s, 3);
        s = '0;
        s.serial_error_request = 1'b1;
        one_ch(s, 4);
        s = '0;
        s.timer_pwm_three_request = 1'b1;
        one_ch(s, 14);
        s = '0;
        s.fault_mux_request = 1'b1;
        one_ch(s, 25);
        s = '0;
        s.fault_pin_request = 1'b1;
        one_ch(s, 30);
    endtask : t_map

    // Disabled high channel is pending but silent
    task automatic t_mask;
        quiet();
        bus_wr(ciu_pkg::CIU_OFS_ENABLE, 32'h00000001);
        drive(32'h00100001);
        wait_clk(4);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000100);
        rd_chk(ciu_pkg::CIU_OFS_PENDING, 32'h00100001);
        bus_wr(ciu_pkg::CIU_OFS_ENABLE, 32'h00000000);
        wait_clk(3);
        chk(norm_irq, 1'b0);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000000);
    endtask : t_mask

    // Per channel routing to the two levels
    task automatic t_route;
        quiet();
        bus_wr(ciu_pkg::CIU_OFS_ENABLE, 32'hFFFFFFFF);
        // Two fast channels, so the fast encoder has a lower one to beat
        bus_wr(ciu_pkg::CIU_OFS_FAST_SEL, 32'h00000404);
        drive(32'h00100404);
        wait_clk(5);
        chk({fast_irq, norm_irq, taken}, 4'hE);
        rd_chk(ciu_pkg::CIU_OFS_FAST_IDX, 32'h0000010A);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h00000114);
        bus_wr(ciu_pkg::CIU_OFS_FAST_SEL, 32'h00000000);
    endtask : t_route

    // Software control raises channel 31
    task automatic t_sw;
        quiet();
        bus_wr(ciu_pkg::CIU_OFS_SW_REQ, 32'h00000001);
        wait_clk(4);
        rd_chk(ciu_pkg::CIU_OFS_PENDING, 32'h80000000);
        rd_chk(ciu_pkg::CIU_OFS_NORM_IDX, 32'h0000011F);
        bus_wr(ciu_pkg::CIU_OFS_SW_REQ, 32'h00000000);
    endtask : t_sw

    // Event status: capture, overrun, read clear, mask
    task automatic t_evt;
        quiet();
        bus_wr(ciu_pkg::CIU_OFS_EVT_MASK, 32'h00000003);
        bus_rd(ciu_pkg::CIU_OFS_EVT_STATUS, d);
        wait_clk(3);
        chk(evt_irq, 1'b0);
        drive(32'h00000004);
        wait_clk(4);
        chk(evt_irq, 1'b1);
        rd_chk(ciu_pkg::CIU_OFS_EVT_STATUS, 32'h00000002);
        wait_clk(3);
        chk(evt_irq, 1'b0);
        drive(32'h00000000);
        wait_clk(2);
        drive(32'h00000004);
        wait_clk(4);
        bus_rd(ciu_pkg::CIU_OFS_EVT_STATUS, d);
        chk(d & 32'h00000001, 32'h00000001);
        bus_wr(ciu_pkg::CIU_OFS_EVT_MASK, 32'h00000000);
        quiet();
        drive(32'h00000008);
        wait_clk(4);
        chk(evt_irq, 1'b0);
    endtask : t_evt

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        wait_clk(2);
        t_reset();
        t_walk();
        t_prec();
        t_map();
        t_mask();
        t_route();
        t_sw();
        t_evt();
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        n_fail++;
        finish_test();
    end
endmodule : tb_central_interrupt_module
